// ==== spi_access_consts.svh ====
// shared constants of the serial register access link
// assumes inclusion by bare name from every design file of both ends
`ifndef SPI_ACCESS_CONSTS_SVH
`define SPI_ACCESS_CONSTS_SVH

// ----------------------------------------------------------------
// frame layout, counted in serial clocks
// ----------------------------------------------------------------
`define SPI_HDR_BITS    6'h1b
`define SPI_HDR_LAST    6'h1a
`define SPI_DATA_START  6'h20
`define SPI_BYTE_LAST   3'h7
`define SPI_BYTE_FIRST  3'h0
`define SPI_CMD_RD      3'h3
`define SPI_CMD_WR      3'h2
// nonzero don't-care fill, so the device is seen to ignore it
`define SPI_ADDR_PAD    8'h5a
`define SPI_TA_FILL     5'h15
`define SPI_ADDR_STEP   16'h0001

// ----------------------------------------------------------------
// host side timing and counts
// ----------------------------------------------------------------
`define HOST_HALF_DIV   4'h4
`define HOST_DIV_ONE    4'h1
`define HOST_DATA_START 12'h020
`define HOST_BIT_ONE    12'h001
`define HOST_COUNT_ONE  9'h001

`endif

// ==== spi_access_pkg.sv ====
// types shared by both ends of the serial register access link
// assumes nothing of its surroundings
package spi_access_pkg;

  // ----------------------------------------------------------------
  // management interface selection caught from the strap
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MGMT_SPI  = 2'b00,
    MGMT_I2C  = 2'b01,
    MGMT_MIIM = 2'b10
  } mgmt_mode_t;

  // ----------------------------------------------------------------
  // host sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HOST_IDLE  = 3'b000,
    HOST_LEAD  = 3'b001,
    HOST_SHIFT = 3'b010,
    HOST_TAIL  = 3'b011,
    HOST_GAP   = 3'b100
  } host_state_t;

endpackage : spi_access_pkg

// ==== spi_link_if.sv ====
// the four wires between the serial master and the register access slave
// assumes the bench joins both ends through one instance of it
`timescale 1ns/1ps
`default_nettype none

interface spi_link_if;
  logic sclk;
  logic chip_select_n;
  logic host_to_device_line;
  logic device_to_host_out;
  logic device_to_host_oe_n;
  logic device_to_host_line;

  // undriven line reads low here, no pull modelled
  assign device_to_host_line = device_to_host_oe_n ? 1'b0 : device_to_host_out;

  modport device (
    input  sclk,
    input  chip_select_n,
    input  host_to_device_line,
    output device_to_host_out,
    output device_to_host_oe_n
  );

  modport host (
    output sclk,
    output chip_select_n,
    output host_to_device_line,
    input  device_to_host_line
  );
endinterface : spi_link_if

`default_nettype wire

// ==== spi_register_access_master.sv ====
// host end: serial master that runs single and burst register accesses
// assumes clk_i at 200 MHz; link clock made here by a divider
`timescale 1ns/1ps
`default_nettype none
`include "spi_access_consts.svh"

module spi_register_access_master (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  spi_link_if.host         link,
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  count_i,
  input  wire logic [7:0]  wdata_i,
  output logic             wdata_take_o,
  output logic [7:0]       rdata_o,
  output logic             rdata_valid_o,
  output logic             busy_o,
  output logic             done_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  spi_access_pkg::host_state_t state_reg;
  spi_access_pkg::host_state_t state_next;
  logic [3:0]  div_reg;
  logic        sclk_reg;
  logic        cs_n_reg;
  logic [11:0] bit_reg;
  logic [11:0] total_reg;
  logic [31:0] out_sh_reg;
  logic [7:0]  in_sh_reg;
  logic        wr_reg;
  logic        rvalid_reg;
  logic        done_reg;
  logic        miso_s1;
  logic        miso_s2;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire         idle      = (state_reg == spi_access_pkg::HOST_IDLE);
  wire         tick      = (div_reg == (`HOST_HALF_DIV - `HOST_DIV_ONE));
  wire         shifting  = (state_reg == spi_access_pkg::HOST_SHIFT);
  wire         fall      = shifting & tick & sclk_reg;
  wire         rise      = shifting & tick & ~sclk_reg;
  wire [11:0]  bit_next  = bit_reg + `HOST_BIT_ONE;
  wire         last      = (bit_next == total_reg);
  wire         in_data   = (bit_reg >= `HOST_DATA_START);
  wire         on_byte   = (bit_next[2:0] == `SPI_BYTE_FIRST) & (bit_next >= `HOST_DATA_START);
  wire         take_w    = fall & on_byte & ~last & wr_reg;
  wire         rx_byte   = fall & in_data & on_byte & ~wr_reg;
  wire [2:0]   cmd_code  = write_i ? `SPI_CMD_WR : `SPI_CMD_RD;
  wire [8:0]   nbytes    = {1'b0, count_i} + `HOST_COUNT_ONE;
  wire [11:0]  total_new = `HOST_DATA_START + {nbytes, 3'h0};
  wire [31:0]  hdr_word  = {cmd_code, `SPI_ADDR_PAD, addr_i, `SPI_TA_FILL};
  wire [31:0]  out_sh_next =
    (idle & start_i) ? hdr_word :
    take_w           ? {wdata_i, 24'h000000} :
    fall             ? {out_sh_reg[30:0], 1'b0} : out_sh_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      spi_access_pkg::HOST_IDLE:  if (start_i) state_next = spi_access_pkg::HOST_LEAD;
      spi_access_pkg::HOST_LEAD:  if (tick) state_next = spi_access_pkg::HOST_SHIFT;
      spi_access_pkg::HOST_SHIFT: if (fall & last) state_next = spi_access_pkg::HOST_TAIL;
      spi_access_pkg::HOST_TAIL:  if (tick) state_next = spi_access_pkg::HOST_GAP;
      spi_access_pkg::HOST_GAP:   if (tick) state_next = spi_access_pkg::HOST_IDLE;
      default:                    state_next = spi_access_pkg::HOST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // miso sampled at the fall: two sync stages still show the held bit
  always_ff @(posedge clk_i) begin
    miso_s1 <= link.device_to_host_line;
    miso_s2 <= miso_s1;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg  <= spi_access_pkg::HOST_IDLE;
      div_reg    <= 4'h0;
      sclk_reg   <= 1'b0;
      cs_n_reg   <= 1'b1;
      bit_reg    <= 12'h000;
      total_reg  <= 12'h000;
      out_sh_reg <= 32'h00000000;
      in_sh_reg  <= 8'h00;
      wr_reg     <= 1'b0;
      rdata_o    <= 8'h00;
      rvalid_reg <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      div_reg    <= (idle | tick) ? 4'h0 : div_reg + `HOST_DIV_ONE;
      sclk_reg   <= rise ? 1'b1 : (fall ? 1'b0 : sclk_reg);
      cs_n_reg   <= (idle & start_i) ? 1'b0 :
                    ((state_reg == spi_access_pkg::HOST_TAIL) & tick) ? 1'b1 : cs_n_reg;
      bit_reg    <= (idle & start_i) ? 12'h000 : (fall ? bit_next : bit_reg);
      total_reg  <= (idle & start_i) ? total_new : total_reg;
      wr_reg     <= (idle & start_i) ? write_i : wr_reg;
      out_sh_reg <= out_sh_next;
      in_sh_reg  <= (fall & in_data) ? {in_sh_reg[6:0], miso_s2} : in_sh_reg;
      rdata_o    <= rx_byte ? {in_sh_reg[6:0], miso_s2} : rdata_o;
      rvalid_reg <= rx_byte;
      done_reg   <= (state_reg == spi_access_pkg::HOST_GAP) & tick;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.sclk                = sclk_reg;
  assign link.chip_select_n       = cs_n_reg;
  assign link.host_to_device_line = out_sh_reg[31];
  assign wdata_take_o             = take_w;
  assign rdata_valid_o            = rvalid_reg;
  assign busy_o                   = ~idle;
  assign done_o                   = done_reg;

endmodule : spi_register_access_master

`default_nettype wire

// ==== spi_register_access_slave.sv ====
// device end: serial slave giving a host byte access to 16-bit addresses
// assumes the link clock from the master and clk_i at 200 MHz for the
// register file side, whose read data is valid while reg_rd_o is high
//
// Notes on behaviour
// - strap picks interface mode at reset release
// - master drives clock, select, input; device drives output
// - master holds serial clock low when idle
// - each select low period is one access
// - 27 header bits, 5 turnaround, 8 data
// - burst: address steps every eight clocks
// - everything shifts most significant bit first
// - input line sampled on rising clock edges
// - output line changes only on falling edges
// - command 011 reads, 010 writes
// - turnaround input bits are ignored
// - only low 16 address bits decoded
// - whole register space reachable, no filter
`timescale 1ns/1ps
`default_nettype none
`include "spi_access_consts.svh"

module spi_register_access_slave (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [1:0]  mode_strap_i,
  output logic [1:0]       mode_o,
  spi_link_if.device       link,
  output logic [15:0]      reg_addr_o,
  output logic [7:0]       reg_wdata_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  input  wire logic [7:0]  reg_rdata_i
);

  // ----------------------------------------------------------------
  // command decode, used on the header and on every data byte
  // ----------------------------------------------------------------
  // any other code issues no request and leaves the output undriven
  function automatic logic cmd_is_read(input logic [2:0] code);
    return (code == `SPI_CMD_RD);
  endfunction : cmd_is_read

  function automatic logic cmd_is_write(input logic [2:0] code);
    return (code == `SPI_CMD_WR);
  endfunction : cmd_is_write

  // ----------------------------------------------------------------
  // link domain, rising edge: header, counters, write bytes
  // ----------------------------------------------------------------
  logic [5:0]  hdr_cnt_reg;
  logic [2:0]  bit_idx_reg;
  logic [25:0] in_sh_reg;
  logic [2:0]  cmd_reg;
  logic [15:0] next_addr_reg;
  logic        req_tgl_reg;
  logic [15:0] xfer_addr_reg;
  logic [7:0]  xfer_data_reg;
  logic        xfer_wr_reg;

  wire         mosi      = link.host_to_device_line;
  wire [26:0]  in_word   = {in_sh_reg, mosi};
  wire         hdr_done  = (hdr_cnt_reg == `SPI_HDR_LAST);
  wire         in_data   = (hdr_cnt_reg == `SPI_DATA_START);
  wire         in_hdr    = (hdr_cnt_reg < `SPI_HDR_BITS);
  wire         is_rd     = cmd_is_read(cmd_reg);
  wire         is_wr     = cmd_is_write(cmd_reg);
  wire         byte_end  = in_data & (bit_idx_reg == `SPI_BYTE_LAST);
  wire         byte_beg  = in_data & (bit_idx_reg == `SPI_BYTE_FIRST);
  wire [15:0]  hdr_addr  = in_word[15:0];
  wire [7:0]   in_byte   = {in_sh_reg[6:0], mosi};

  // the read of byte k+1 is fetched while byte k shifts out, so a
  // burst read touches one address past the last byte clocked
  wire         rd_issue  = (hdr_done & cmd_is_read(in_word[26:24]))
                         | (byte_beg & is_rd);
  wire         wr_issue  = byte_end & is_wr;
  wire         issue     = rd_issue | wr_issue;
  wire [15:0]  addr_now  = hdr_done ? hdr_addr : next_addr_reg;

  wire [5:0]   hdr_cnt_next   = in_data ? hdr_cnt_reg : hdr_cnt_reg + 6'h01;
  wire [2:0]   bit_idx_next   = in_data ? bit_idx_reg + 3'h1 : `SPI_BYTE_FIRST;
  // turnaround clocks leave the shifter alone
  wire [25:0]  in_sh_next     = (in_hdr | in_data) ? in_word[25:0] : in_sh_reg;
  wire [2:0]   cmd_next       = hdr_done ? in_word[26:24] : cmd_reg;
  wire [15:0]  next_addr_next = issue ? addr_now + `SPI_ADDR_STEP :
                                (hdr_done ? hdr_addr : next_addr_reg);
  wire         req_tgl_next   = req_tgl_reg ^ issue;
  wire [15:0]  xfer_addr_next = issue ? addr_now : xfer_addr_reg;
  wire [7:0]   xfer_data_next = wr_issue ? in_byte : xfer_data_reg;
  wire         xfer_wr_next   = issue ? wr_issue : xfer_wr_reg;

  // select high clears the frame state: every select low starts afresh
  always_ff @(posedge link.sclk or posedge link.chip_select_n) begin
    if (link.chip_select_n) begin
      hdr_cnt_reg   <= 6'h00;
      bit_idx_reg   <= 3'h0;
      in_sh_reg     <= 26'h0000000;
      cmd_reg       <= 3'h0;
      next_addr_reg <= 16'h0000;
      req_tgl_reg   <= 1'b0;
    end else begin
      hdr_cnt_reg   <= hdr_cnt_next;
      bit_idx_reg   <= bit_idx_next;
      in_sh_reg     <= in_sh_next;
      cmd_reg       <= cmd_next;
      next_addr_reg <= next_addr_next;
      req_tgl_reg   <= req_tgl_next;
    end
  end

  // handed-over words: kept through select high so the far side can
  // still pick up a write that ended right at the frame edge
  always_ff @(posedge link.sclk) begin
    xfer_addr_reg <= xfer_addr_next;
    xfer_data_reg <= xfer_data_next;
    xfer_wr_reg   <= xfer_wr_next;
  end

  // ----------------------------------------------------------------
  // link domain, falling edge: read data out
  // ----------------------------------------------------------------
  logic [7:0]  out_sh_reg;
  logic        drive_reg;
  logic [7:0]  rd_hold_reg;

  wire         load        = byte_beg & is_rd;
  // rd_hold_reg settled at least three link clocks before this load
  wire [7:0]   out_sh_next = load ? rd_hold_reg : {out_sh_reg[6:0], 1'b0};
  wire         drive_next  = drive_reg | load;

  always_ff @(negedge link.sclk or posedge link.chip_select_n) begin
    if (link.chip_select_n) begin
      out_sh_reg <= 8'h00;
      drive_reg  <= 1'b0;
    end else begin
      out_sh_reg <= out_sh_next;
      drive_reg  <= drive_next;
    end
  end

  // ----------------------------------------------------------------
  // system domain: strap capture and crossing of the requests
  // ----------------------------------------------------------------
  spi_access_pkg::mgmt_mode_t mode_reg;
  logic [1:0]  strap_s1;
  logic [1:0]  strap_s2;
  logic        rst_d_reg;
  logic        tgl_s1;
  logic        tgl_s2;
  logic        tgl_seen_reg;
  logic        cs_s1;
  logic        cs_s2;

  wire         spi_mode  = (mode_reg == spi_access_pkg::MGMT_SPI);
  wire         release_w = rst_d_reg & ~sys_rst_i;
  // taking only while select is low drops the toggle cleared by deselect
  wire         take      = (tgl_s2 ^ tgl_seen_reg) & ~cs_s2 & spi_mode;
  // no address filter: every 16-bit location reaches the register file
  wire [15:0]  addr_next  = take ? xfer_addr_reg : reg_addr_o;
  wire [7:0]   wdata_next = take ? xfer_data_reg : reg_wdata_o;
  wire [7:0]   hold_next  = reg_rd_o ? reg_rdata_i : rd_hold_reg;
  wire         seen_next  = cs_s2 ? 1'b0 : tgl_s2;

  always_ff @(posedge clk_i) begin
    strap_s1 <= mode_strap_i;
    strap_s2 <= strap_s1;
    tgl_s1   <= req_tgl_reg;
    tgl_s2   <= tgl_s1;
    cs_s1    <= link.chip_select_n;
    cs_s2    <= cs_s1;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_reg     <= spi_access_pkg::MGMT_SPI;
      rst_d_reg    <= 1'b1;
      tgl_seen_reg <= 1'b0;
      reg_addr_o   <= 16'h0000;
      reg_wdata_o  <= 8'h00;
      reg_wr_o     <= 1'b0;
      reg_rd_o     <= 1'b0;
      rd_hold_reg  <= 8'h00;
    end else begin
      mode_reg     <= release_w ? spi_access_pkg::mgmt_mode_t'(strap_s2) : mode_reg;
      rst_d_reg    <= 1'b0;
      tgl_seen_reg <= seen_next;
      reg_addr_o   <= addr_next;
      reg_wdata_o  <= wdata_next;
      reg_wr_o     <= take & xfer_wr_reg;
      reg_rd_o     <= take & ~xfer_wr_reg;
      rd_hold_reg  <= hold_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the mode level is static after reset, so gating the pin with it
  // across domains cannot glitch during a frame
  assign link.device_to_host_out  = out_sh_reg[7];
  assign link.device_to_host_oe_n = ~(drive_reg & spi_mode);
  assign mode_o                   = mode_reg;

endmodule : spi_register_access_slave

`default_nettype wire

// ==== spi_link_properties.sv ====
// concurrent checks on the four wires between the register access master and slave
// assumes clk_i clocks the master, which divides it by eight to make sclk
`timescale 1ns/1ps
`default_nettype none

module spi_link_properties (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       sclk,
  input  wire logic       chip_select_n,
  input  wire logic       host_to_device_line,
  input  wire logic       device_to_host_out,
  input  wire logic       device_to_host_oe_n,
  input  wire logic       device_to_host_line,
  input  wire logic [1:0] mode_o
);
  // ----------------------------------------------------------------
  // helper logic: rises per frame and the command field
  // ----------------------------------------------------------------
  logic        sclk_reg;
  logic [11:0] rise_cnt_reg;
  logic [2:0]  cmd_reg;
  wire         sclk_rise = sclk & ~sclk_reg;
  wire         is_read   = (cmd_reg == 3'h3) & (rise_cnt_reg >= 12'h003);
  wire         is_spi    = (mode_o == 2'h0);

  always_ff @(posedge clk_i) begin
    sclk_reg <= sclk;
  end

  // cleared by deselect so each frame counts on its own
  always_ff @(posedge clk_i) begin
    if (sys_rst_i | chip_select_n) begin
      rise_cnt_reg <= 12'h000;
    end else if (sclk_rise) begin
      rise_cnt_reg <= rise_cnt_reg + 12'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i | chip_select_n) begin
      cmd_reg <= 3'h0;
    end else if (sclk_rise & (rise_cnt_reg < 12'h003)) begin
      cmd_reg <= {cmd_reg[1:0], host_to_device_line};
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // lead state and one low half period pass before the first rise
  sequence lead_s;
    !sclk[*8] ##1 sclk;
  endsequence

  sequence half_high_s;
    sclk[*4] ##1 !sclk;
  endsequence

  AST_SCLK_IDLE_LOW: assert property (chip_select_n |-> !sclk)
    else $error("serial clock high while deselected");
  AST_LEAD_BEFORE_RISE: assert property ($fell(chip_select_n) |-> lead_s)
    else $error("first serial clock rise not two half periods after select");
  AST_HALF_PERIOD: assert property ($rose(sclk) |-> half_high_s)
    else $error("serial clock high phase has the wrong length");
  AST_DESELECT_GAP: assert property ($rose(chip_select_n) |-> chip_select_n[*4])
    else $error("select idle gap too short");
  AST_WHOLE_BYTES: assert property ($rose(chip_select_n) |->
    (rise_cnt_reg >= 12'h028) && (rise_cnt_reg[2:0] == 3'h0))
    else $error("frame not header plus whole bytes");
  AST_HIZ_DESELECTED: assert property (chip_select_n |-> device_to_host_oe_n)
    else $error("output line driven while deselected");
  AST_DRIVE_READ_DATA_ONLY: assert property (!device_to_host_oe_n |->
    is_spi && is_read && (rise_cnt_reg >= 12'h020))
    else $error("output line driven outside read data");
  AST_DRIVE_STARTS: assert property (is_spi && is_read
    && (rise_cnt_reg == 12'h020) && $fell(sclk) |-> ##[0:1] !device_to_host_oe_n)
    else $error("read data phase not driven");
  AST_OUT_ON_FALL: assert property (!chip_select_n && $past(!chip_select_n)
    && $changed(device_to_host_out) |-> $fell(sclk))
    else $error("output bit changed away from a falling clock edge");
  AST_IN_ON_FALL: assert property (!chip_select_n && $past(!chip_select_n)
    && $changed(host_to_device_line) |-> $fell(sclk))
    else $error("input bit changed away from a falling clock edge");

  COV_READ_DATA: cover property (!device_to_host_oe_n && device_to_host_line);
endmodule : spi_link_properties

`default_nettype wire

// ==== spi_register_access_slave_tb.sv ====
// self-checking bench joining the register access master and slave
// assumes both ends share clk_i; a byte array stands in for the register file
`timescale 1ns/1ps
`default_nettype none

module spi_register_access_slave_tb;
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  cnt;
    logic [7:0]  base;
  } row_t;

  // ----------------------------------------------------------------
  // signals and models
  // ----------------------------------------------------------------
  logic        clk_i      = 1'b0;
  logic        sys_rst_i  = 1'b1;
  logic [1:0]  mode_strap = 2'h0;
  logic        start      = 1'b0;
  logic        wr_sel     = 1'b0;
  logic [15:0] addr       = 16'h0000;
  logic [7:0]  cnt        = 8'h00;
  logic [7:0]  wdata      = 8'h00;
  logic        wdata_take, rdata_valid, busy, done, reg_wr, reg_rd;
  logic [7:0]  rdata, reg_wdata, reg_rdata;
  logic [15:0] reg_addr, ta;
  logic [1:0]  mode;
  logic [7:0]  mem     [0:65535];
  logic [7:0]  exp_mem [0:65535];
  logic [7:0]  got     [$];
  row_t        rw;
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  int          wr_pulses  = 0;
  int          rd_pulses  = 0;
  // wrap rows cross ffff to 0000 on purpose
  row_t        rows [6] = '{'{1'b1, 16'h1234, 8'h00, 8'ha5}, '{1'b0, 16'h1234, 8'h00, 8'h00},
                            '{1'b1, 16'hfffe, 8'h03, 8'h70}, '{1'b0, 16'hfffd, 8'h05, 8'h00},
                            '{1'b0, 16'h0000, 8'h00, 8'h00}, '{1'b1, 16'h8000, 8'h07, 8'h11}};

  always #2.5 clk_i = ~clk_i;

  spi_link_if spi_link_if_i ();

  spi_register_access_master spi_register_access_master_i (
    .clk_i (clk_i), .sys_rst_i (sys_rst_i), .link (spi_link_if_i), .start_i (start),
    .write_i (wr_sel), .addr_i (addr), .count_i (cnt), .wdata_i (wdata),
    .wdata_take_o (wdata_take), .rdata_o (rdata), .rdata_valid_o (rdata_valid),
    .busy_o (busy), .done_o (done));

  spi_register_access_slave spi_register_access_slave_i (
    .clk_i (clk_i), .sys_rst_i (sys_rst_i), .mode_strap_i (mode_strap), .mode_o (mode),
    .link (spi_link_if_i), .reg_addr_o (reg_addr), .reg_wdata_o (reg_wdata),
    .reg_wr_o (reg_wr), .reg_rd_o (reg_rd), .reg_rdata_i (reg_rdata));

  spi_link_properties spi_link_properties_i (
    .clk_i (clk_i), .sys_rst_i (sys_rst_i), .sclk (spi_link_if_i.sclk),
    .chip_select_n (spi_link_if_i.chip_select_n),
    .host_to_device_line (spi_link_if_i.host_to_device_line),
    .device_to_host_out (spi_link_if_i.device_to_host_out),
    .device_to_host_oe_n (spi_link_if_i.device_to_host_oe_n),
    .device_to_host_line (spi_link_if_i.device_to_host_line), .mode_o (mode));

  assign reg_rdata = mem[reg_addr];

  always @(posedge clk_i) begin
    if (reg_wr === 1'b1) begin
      mem[reg_addr] <= reg_wdata;
      wr_pulses++;
    end
    if (reg_rd === 1'b1) begin
      rd_pulses++;
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : pat

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // strap held through the whole reset so the synchroniser has settled
  task automatic do_reset(input logic [1:0] strap);
    @(posedge clk_i);
    #1 sys_rst_i = 1'b1;
    mode_strap = strap;
    repeat (10) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : do_reset

  // write bytes advance one edge after the master has taken them
  task automatic run_frame(input logic w, input logic [15:0] a, input logic [7:0] c,
                           input logic [7:0] b);
    int  k;
    int  guard;
    logic take_seen;
    k = 0;
    take_seen = 1'b0;
    got.delete();
    wr_pulses = 0;
    rd_pulses = 0;
    wr_sel = w;
    addr = a;
    cnt = c;
    wdata = b;
    start = 1'b1;
    @(posedge clk_i);
    #1 start = 1'b0;
    for (guard = 0; guard < 20000 && done !== 1'b1; guard++) begin
      if (take_seen) begin
        k++;
        wdata = b + 8'(k);
      end
      take_seen = (wdata_take === 1'b1);
      if (rdata_valid === 1'b1) got.push_back(rdata);
      @(posedge clk_i);
      #1;
    end
    if (guard >= 20000) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : run_frame

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int j = 0; j < 65536; j++) begin
      mem[j] = pat(16'(j));
      exp_mem[j] = pat(16'(j));
    end
    do_reset(2'h0);
    check({15'h0000, busy}, 16'h0000);
    check({15'h0000, spi_link_if_i.device_to_host_oe_n}, 16'h0001);
    check({14'h0000, mode}, 16'h0000);
    foreach (rows[r]) begin
      rw = rows[r];
      run_frame(rw.wr, rw.addr, rw.cnt, rw.base);
      check(16'(got.size()), rw.wr ? 16'h0000 : 16'(rw.cnt) + 16'h0001);
      check(16'(wr_pulses), rw.wr ? 16'(rw.cnt) + 16'h0001 : 16'h0000);
      for (int i = 0; i <= int'(rw.cnt); i++) begin
        ta = rw.addr + 16'(i);
        if (rw.wr) begin
          exp_mem[ta] = rw.base + 8'(i);
          check({8'h00, mem[ta]}, {8'h00, exp_mem[ta]});
        end else begin
          check({8'h00, got[i]}, {8'h00, exp_mem[ta]});
        end
      end
    end
    // another strap: the link must stay silent and issue no strobes
    do_reset(2'h1);
    check({14'h0000, mode}, 16'h0001);
    run_frame(1'b1, 16'h1234, 8'h00, 8'h0f);
    check(16'(wr_pulses), 16'h0000);
    run_frame(1'b0, 16'h1234, 8'h00, 8'h00);
    check(16'(rd_pulses), 16'h0000);
    do_reset(2'h0);
    check({14'h0000, mode}, 16'h0000);
    // a strap change after release must not move the mode
    mode_strap = 2'h2;
    repeat (4) @(posedge clk_i);
    #1;
    check({14'h0000, mode}, 16'h0000);
    run_frame(1'b0, 16'h1234, 8'h00, 8'h00);
    check({8'h00, got[0]}, {8'h00, exp_mem[16'h1234]});
    give_verdict();
  end
endmodule : spi_register_access_slave_tb

`default_nettype wire
